// [verilog/bsp_sram_port.sv]
// Operation
// - clock qualifier high freezes all state except the burst order strap synchronizer
// - load address when selected with load
// - read data appears next qualified edge
// - output enable gates drivers at once, without waiting for a clock edge
// - new command accepted right after read
// - deselect floats outputs one edge later
// - burst counter steps through four accesses, then wraps and keeps going until the next load
// - strap low: linear plus-one burst order
// - strap high: start xor count order
// - counter wraps inside four-word group
// - advance ignores chip selects and write strobe
// - access type fixed for whole burst
// - write command latches address and controls
// - edge after write floats data lines
// - write data captured second edge after command
// - only selected byte lanes are stored
// - outputs float first clock after deselect
// - lane x covers eight bits plus parity
// - power-up deselected with outputs floating
`timescale 1ns/1ps
module bsp_sram_port #(
  parameter int ADDR_W = bsp_pkg::ADDR_W
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic                     clock_qualify_n,
  input  wire logic                     chip_select_a_n,
  input  wire logic                     chip_select_b,
  input  wire logic                     chip_select_c_n,
  input  wire logic                     advance_or_load_n,
  input  wire logic                     write_strobe_n,
  input  wire logic [bsp_pkg::LANES-1:0] byte_lane_select_n,
  input  wire logic [ADDR_W-1:0]        address,
  input  wire logic                     burst_order_strap,
  input  wire logic                     output_drive_en_n,
  input  wire logic [bsp_pkg::DQ_W-1:0] data_in,
  output logic      [bsp_pkg::DQ_W-1:0] data_out,
  output logic                          data_oe,
  input  wire logic [bsp_pkg::LANES-1:0] parity_lines_in,
  output logic      [bsp_pkg::LANES-1:0] parity_lines_out,
  output logic                          parity_lines_oe
);

  localparam int LN = bsp_pkg::LANES;
  localparam int WW = bsp_pkg::WORD_W;
  localparam int BW = bsp_pkg::BURST_W;
  localparam int FW = ADDR_W + LN + WW;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]        mode_sync;
    logic [ADDR_W-1:0] addr;
    logic [BW-1:0]     start;
    logic [BW-1:0]     cnt;
    logic              burst_on;
    logic              burst_write;
    bsp_pkg::bsp_op_t  s1_op;
    logic [ADDR_W-1:0] s1_addr;
    logic [LN-1:0]     s1_mask_n;
    logic              s2_wr;
    logic [ADDR_W-1:0] s2_addr;
    logic [LN-1:0]     s2_mask_n;
    logic [WW-1:0]     out_word;
    logic              drive;
  } bsp_state_t;

  bsp_state_t        st_ff;
  bsp_state_t        nxt_st;
  logic [WW-1:0]     mem [0:(2**ADDR_W)-1];
  logic              selected;
  logic              hold;
  logic              wb_in_valid;
  logic              wb_in_ready;
  logic [FW-1:0]     wb_in_data;
  logic              wb_out_valid;
  logic              wb_out_ready;
  logic [FW-1:0]     wb_out_data;
  logic [ADDR_W-1:0] wb_head_addr;
  logic [LN-1:0]     wb_head_mask_n;
  logic [WW-1:0]     wb_head_word;
  logic [WW-1:0]     pin_word;
  logic [WW-1:0]     fetch_word;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [BW-1:0] burst_low(input logic [BW-1:0] start,
                                              input logic [BW-1:0] cnt,
                                              input logic          interleave);
    if (interleave) begin
      burst_low = start ^ cnt;
    end else begin
      burst_low = BW'(start + cnt);
    end
  endfunction : burst_low

  // lane x = data bits 8x+7..8x with parity bit x
  function automatic logic [WW-1:0] lane_merge(input logic [WW-1:0] old_word,
                                               input logic [WW-1:0] new_word,
                                               input logic [LN-1:0] mask_n);
    lane_merge = old_word;
    for (int x = 0; x < LN; x++) begin
      if (!mask_n[x]) begin
        lane_merge[x*bsp_pkg::LANE_BITS +: bsp_pkg::LANE_BITS] =
          new_word[x*bsp_pkg::LANE_BITS +: bsp_pkg::LANE_BITS];
        lane_merge[bsp_pkg::DQ_W + x] = new_word[bsp_pkg::DQ_W + x];
      end
    end
  endfunction : lane_merge

  // ----------------------------------------------------------------
  // write buffer
  // ----------------------------------------------------------------
  assign selected     = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  assign hold         = clock_qualify_n || !wb_in_ready;
  assign pin_word     = {parity_lines_in, data_in};
  assign wb_in_valid  = !hold && st_ff.s2_wr;
  assign wb_in_data   = {st_ff.s2_addr, st_ff.s2_mask_n, pin_word};
  // drain stalls with the clock qualifier so a suspend really freezes the array
  assign wb_out_ready = !clock_qualify_n;
  assign {wb_head_addr, wb_head_mask_n, wb_head_word} = wb_out_data;

  bsp_fifo #(
    .W     (FW),
    .DEPTH (bsp_pkg::WBUF_DEPTH)
  ) u_wbuf (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (wb_in_valid),
    .in_ready  (wb_in_ready),
    .in_data   (wb_in_data),
    .out_valid (wb_out_valid),
    .out_ready (wb_out_ready),
    .out_data  (wb_out_data)
  );

  // array is not reset; contents are undefined after power-up
  always_ff @(posedge clk_sys) begin
    if (wb_out_valid && wb_out_ready) begin
      mem[wb_head_addr] <= lane_merge(mem[wb_head_addr], wb_head_word, wb_head_mask_n);
    end
  end

  // ----------------------------------------------------------------
  // read fetch with forwarding of writes not yet in the array
  // ----------------------------------------------------------------
  // only the buffer head is forwarded; push and drain stop together on a suspend, so no deeper backlog builds
  always_comb begin
    fetch_word = mem[st_ff.s1_addr];
    if (wb_out_valid && (wb_head_addr == st_ff.s1_addr)) begin
      fetch_word = lane_merge(fetch_word, wb_head_word, wb_head_mask_n);
    end
    if (st_ff.s2_wr && (st_ff.s2_addr == st_ff.s1_addr)) begin
      fetch_word = lane_merge(fetch_word, pin_word, st_ff.s2_mask_n);
    end
  end

  // ----------------------------------------------------------------
  // command and pipeline
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.mode_sync = {st_ff.mode_sync[0], burst_order_strap};
    if (!hold) begin
      // fetch and data stages advance behind the command stage
      nxt_st.drive     = (st_ff.s1_op == bsp_pkg::BSP_OP_READ);
      if (st_ff.s1_op == bsp_pkg::BSP_OP_READ) begin
        nxt_st.out_word = fetch_word;
      end
      nxt_st.s2_wr     = (st_ff.s1_op == bsp_pkg::BSP_OP_WRITE);
      nxt_st.s2_addr   = st_ff.s1_addr;
      nxt_st.s2_mask_n = st_ff.s1_mask_n;
      if (!advance_or_load_n) begin
        if (selected) begin
          nxt_st.addr        = address;
          nxt_st.start       = address[BW-1:0];
          nxt_st.cnt         = bsp_pkg::RST_BURST;
          nxt_st.burst_on    = 1'b1;
          nxt_st.burst_write = !write_strobe_n;
          nxt_st.s1_op       = write_strobe_n ? bsp_pkg::BSP_OP_READ : bsp_pkg::BSP_OP_WRITE;
          nxt_st.s1_addr     = address;
          nxt_st.s1_mask_n   = byte_lane_select_n;
        end else begin
          nxt_st.burst_on    = 1'b0;
          nxt_st.s1_op       = bsp_pkg::BSP_OP_NONE;
        end
      end else if (st_ff.burst_on) begin
        // chip selects and strobe are not looked at on a continuation
        nxt_st.cnt       = BW'(st_ff.cnt + 1'b1);
        nxt_st.s1_op     = st_ff.burst_write ? bsp_pkg::BSP_OP_WRITE : bsp_pkg::BSP_OP_READ;
        nxt_st.s1_addr   = {st_ff.addr[ADDR_W-1:BW],
                            burst_low(st_ff.start, BW'(st_ff.cnt + 1'b1), st_ff.mode_sync[1])};
        nxt_st.s1_mask_n = byte_lane_select_n;
      end else begin
        nxt_st.s1_op     = bsp_pkg::BSP_OP_NONE;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff             <= '0;
      st_ff.mode_sync   <= bsp_pkg::RST_MODE;
      st_ff.s1_op       <= bsp_pkg::BSP_OP_NONE;
      st_ff.s1_mask_n   <= bsp_pkg::RST_MASK_N;
      st_ff.s2_mask_n   <= bsp_pkg::RST_MASK_N;
      st_ff.drive       <= bsp_pkg::RST_DRIVE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  assign data_out         = st_ff.out_word[bsp_pkg::DQ_W-1:0];
  assign parity_lines_out = st_ff.out_word[WW-1:bsp_pkg::DQ_W];
  // enable stays asynchronous so the bus can be released between edges
  assign data_oe          = st_ff.drive && !output_drive_en_n;
  assign parity_lines_oe  = st_ff.drive && !output_drive_en_n;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_cmd_read;
    !clock_qualify_n && wb_in_ready && !advance_or_load_n && selected && write_strobe_n;
  endsequence

  sequence s_cmd_write;
    !clock_qualify_n && wb_in_ready && !advance_or_load_n && selected && !write_strobe_n;
  endsequence

  a_suspend_holds: assert property (
    clock_qualify_n |=> (st_ff.s1_op == $past(st_ff.s1_op)) && (st_ff.addr == $past(st_ff.addr))
                        && (st_ff.cnt == $past(st_ff.cnt)) && (st_ff.drive == $past(st_ff.drive)))
    else $error("state moved during suspend");

  a_load_address: assert property (
    (!clock_qualify_n && wb_in_ready && !advance_or_load_n && selected)
      |=> (st_ff.addr == $past(address)) && (st_ff.cnt == 2'h0))
    else $error("address not loaded");

  a_read_drives: assert property (
    s_cmd_read ##1 (!clock_qualify_n && wb_in_ready) |=> st_ff.drive)
    else $error("read data not driven next edge");

  a_write_floats: assert property (
    s_cmd_write ##1 (!clock_qualify_n && wb_in_ready) |=> !st_ff.drive ##0 !data_oe)
    else $error("outputs driven after write command");

  a_deselect_float: assert property (
    (!clock_qualify_n && wb_in_ready && !advance_or_load_n && !selected)
      ##1 (!clock_qualify_n && wb_in_ready) |=> !data_oe && !parity_lines_oe)
    else $error("outputs not floated after deselect");

  a_enable_gates: assert property (
    output_drive_en_n |-> !data_oe && !parity_lines_oe)
    else $error("drivers on with enable high");

  a_burst_count: assert property (
    (!clock_qualify_n && wb_in_ready && advance_or_load_n && st_ff.burst_on)
      |=> st_ff.cnt == 2'($past(st_ff.cnt) + 2'h1))
    else $error("burst counter did not step");

  a_linear_order: assert property (
    (!clock_qualify_n && wb_in_ready && advance_or_load_n && st_ff.burst_on && !st_ff.mode_sync[1])
      |=> st_ff.s1_addr[1:0] == 2'($past(st_ff.s1_addr[1:0]) + 2'h1))
    else $error("linear burst address wrong");

  a_interleave_order: assert property (
    (!clock_qualify_n && wb_in_ready && advance_or_load_n && st_ff.burst_on && st_ff.mode_sync[1])
      |=> st_ff.s1_addr[1:0] == (st_ff.start ^ st_ff.cnt))
    else $error("interleaved burst address wrong");

  a_type_kept: assert property (
    (!clock_qualify_n && wb_in_ready && advance_or_load_n && st_ff.burst_on && st_ff.burst_write)
      |=> st_ff.s1_op == bsp_pkg::BSP_OP_WRITE)
    else $error("burst write turned into read");

  a_write_capture: assert property (
    s_cmd_write ##1 (!clock_qualify_n && wb_in_ready) ##1 (!clock_qualify_n && wb_in_ready)
      |-> wb_in_valid && (wb_in_data[WW-1:0] == pin_word) && (wb_in_data[FW-1 -: ADDR_W] == $past(address, 2))
          && (wb_in_data[WW +: LN] == $past(byte_lane_select_n, 2)))
    else $error("write data not captured on second edge");

  a_advance_idle: assert property (
    (!hold && advance_or_load_n && !st_ff.burst_on) |=> st_ff.s1_op == bsp_pkg::BSP_OP_NONE)
    else $error("advance without burst started an access");

  a_mask_latched: assert property (
    s_cmd_write |=> (st_ff.s1_op == bsp_pkg::BSP_OP_WRITE) && (st_ff.s1_mask_n == $past(byte_lane_select_n)))
    else $error("write controls not latched");

  a_resume_float: assert property (
    (!hold && !advance_or_load_n && !selected) ##1 s_cmd_read |=> !data_oe && !parity_lines_oe)
    else $error("outputs driven in first clock after deselect");

  a_wrap_group: assert property (
    (!hold && advance_or_load_n && st_ff.burst_on)
      |=> st_ff.s1_addr[ADDR_W-1:BW] == $past(st_ff.s1_addr[ADDR_W-1:BW]))
    else $error("burst carried out of its group");

  a_float_nonread: assert property (
    (!hold && (st_ff.s1_op != bsp_pkg::BSP_OP_READ)) |=> !st_ff.drive)
    else $error("drive set for a non-read");

  a_power_up_float: assert property (
    $rose(rst_n) |-> !data_oe && !parity_lines_oe && (st_ff.s1_op == bsp_pkg::BSP_OP_NONE))
    else $error("outputs not floating after power-up");

  a_suspend_drain: assert property (
    clock_qualify_n |=> (wb_out_valid == $past(wb_out_valid)) && (wb_out_data == $past(wb_out_data)))
    else $error("write buffer moved during suspend");

  a_beat_mask: assert property (
    (!hold && advance_or_load_n && st_ff.burst_on && st_ff.burst_write)
      |=> st_ff.s1_mask_n == $past(byte_lane_select_n))
    else $error("beat lane selects not taken");

  a_read_kept: assert property (
    (!hold && advance_or_load_n && st_ff.burst_on && !st_ff.burst_write)
      |=> st_ff.s1_op == bsp_pkg::BSP_OP_READ)
    else $error("burst read turned into write");

  a_back_to_back: assert property (
    s_cmd_read ##1 (!hold && !advance_or_load_n && selected)
      |=> (st_ff.s1_op != bsp_pkg::BSP_OP_NONE) && (st_ff.s1_addr == $past(address)))
    else $error("command after read not accepted");

  c_read_single: cover property (s_cmd_read ##1 !clock_qualify_n ##1 data_oe);
  c_write_single: cover property (s_cmd_write ##2 wb_in_valid);
  c_burst_four: cover property (s_cmd_read ##1 (!clock_qualify_n && advance_or_load_n) [*3]);
  c_suspend: cover property (st_ff.s1_op == bsp_pkg::BSP_OP_READ ##0 clock_qualify_n [*2]);
  c_read_write: cover property (s_cmd_read ##1 s_cmd_write);

endmodule : bsp_sram_port

// [verilog/bsp_pkg.sv]
package bsp_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 17;
  localparam int          LANES        = 4;
  localparam int          LANE_BITS    = 8;
  localparam int          DQ_W         = LANES * LANE_BITS;
  localparam int          WORD_W       = DQ_W + LANES;
  localparam int          BURST_W      = 2;
  localparam int          WBUF_DEPTH   = 4;
  localparam int          WBUF_W       = ADDR_W + LANES + WORD_W;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  RST_BURST    = 2'h0;
  localparam logic        RST_DRIVE    = 1'h0;
  localparam logic [1:0]  RST_MODE     = 2'h3;
  localparam logic [3:0]  RST_MASK_N   = 4'hf;

  // ----------------------------------------------------------------
  // pipeline operation codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BSP_OP_NONE  = 3'b001,
    BSP_OP_READ  = 3'b010,
    BSP_OP_WRITE = 3'b100
  } bsp_op_t;

endpackage : bsp_pkg

// [verilog/bsp_fifo.sv]
`timescale 1ns/1ps
module bsp_fifo #(
  parameter int W     = 57,
  parameter int DEPTH = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] slot;
    logic [PW-1:0]           wr;
    logic [PW-1:0]           rd;
    logic [CW-1:0]           cnt;
  } bsp_fifo_state_t;

  bsp_fifo_state_t st_ff;
  bsp_fifo_state_t nxt_st;
  logic            push;
  logic            pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : bump

  assign in_ready  = (st_ff.cnt != CW'(DEPTH));
  assign out_valid = (st_ff.cnt != '0);
  assign out_data  = st_ff.slot[st_ff.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.slot[st_ff.wr] = in_data;
      nxt_st.wr             = bump(st_ff.wr);
    end
    if (pop) begin
      nxt_st.rd = bump(st_ff.rd);
    end
    if (push && !pop) begin
      nxt_st.cnt = CW'(st_ff.cnt + 1'b1);
    end else if (pop && !push) begin
      nxt_st.cnt = CW'(st_ff.cnt - 1'b1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : bsp_fifo

// [tb/bsp_ctrl_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// controller side of the shared data and parity lines
// ----------------------------------------------------------------
module bsp_ctrl_model (
  input  wire logic        clk_sys,
  input  wire logic        data_oe,
  input  wire logic        parity_lines_oe,
  input  wire logic [31:0] data_out,
  input  wire logic [3:0]  parity_lines_out,
  input  wire logic        wr_en,
  input  wire logic [35:0] wr_word,
  output logic      [31:0] data_in,
  output logic      [3:0]  parity_lines_in,
  output logic             clash
);
  logic [35:0] idle_ff = 36'h0;

  // a released bus never shows a stale word
  always @(posedge clk_sys) idle_ff <= ~idle_ff;

  always_comb begin
    clash = wr_en & (data_oe | parity_lines_oe);
    if (wr_en)
      {parity_lines_in, data_in} = wr_word;
    else if (data_oe)
      {parity_lines_in, data_in} = {parity_lines_out, data_out};
    else
      {parity_lines_in, data_in} = idle_ff;
  end
endmodule : bsp_ctrl_model

// [tb/tb_bsp_sram_port.sv]
`timescale 1ns/1ps
module tb_bsp_sram_port;
  localparam logic [16:0] GRP = 17'h00a40;
  logic        clk_sys = 1'b0, rst_n = 1'b0, clock_qualify_n = 1'b0;
  logic        chip_select_a_n = 1'b1, chip_select_b = 1'b0, chip_select_c_n = 1'b1;
  logic        advance_or_load_n = 1'b0, write_strobe_n = 1'b1, burst_order_strap = 1'b0;
  logic        output_drive_en_n = 1'b0, wr_en = 1'b0, clash, data_oe, parity_lines_oe;
  logic        bwr = 1'b0, bact = 1'b0;
  logic [1:0]  bcnt = 2'h0, kind = 2'h0;
  logic [3:0]  byte_lane_select_n = 4'hf, parity_lines_in, parity_lines_out;
  logic [16:0] address = 17'h0, badr = 17'h0;
  logic [31:0] data_in, data_out;
  logic [35:0] wr_word = 36'h0, rexp = 36'h0, hexp = 36'h0;
  logic [57:0] pipe0 = 58'h0, pipe1 = 58'h0;
  logic [35:0] mem [logic [16:0]];
  int          n_mismatch = 0, compares = 0;

  bsp_sram_port u_bsp_sram_port (.clk_sys, .rst_n, .clock_qualify_n, .chip_select_a_n,
    .chip_select_b, .chip_select_c_n, .advance_or_load_n, .write_strobe_n,
    .byte_lane_select_n, .address, .burst_order_strap, .output_drive_en_n, .data_in,
    .data_out, .data_oe, .parity_lines_in, .parity_lines_out, .parity_lines_oe);
  bsp_ctrl_model u_bsp_ctrl_model (.clk_sys, .data_oe, .parity_lines_oe, .data_out,
    .parity_lines_out, .wr_en, .wr_word, .data_in, .parity_lines_in, .clash);

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // compares and verdict
  // ----------------------------------------------------------------
  task automatic chk_w(input string nm, input logic [35:0] e, input logic [35:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_w

  task automatic chk_b(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_b

  task automatic print_verdict();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  function automatic logic [35:0] merge(input logic [35:0] o, n, input logic [3:0] m);
    for (int x = 0; x < 4; x++) begin
      if (!m[x]) begin
        o[8*x +: 8] = n[8*x +: 8];
        o[32+x] = n[32+x];
      end
    end
    return o;
  endfunction : merge

  // ----------------------------------------------------------------
  // one qualified cycle; judges the previous command's result
  // ----------------------------------------------------------------
  task automatic cyc(input logic ld_n, we_n, sel, input logic [3:0] m, input logic [16:0] a,
                     input logic [35:0] w);
    logic [16:0] ea;
    logic [1:0]  k;
    logic [35:0] nexp;
    if (!ld_n) begin
      bact = sel;
      bwr = !we_n;
      badr = a;
      bcnt = 2'h0;
    end else begin
      bcnt = bcnt + 2'h1;
    end
    ea = {badr[16:2], burst_order_strap ? badr[1:0] ^ bcnt : badr[1:0] + bcnt};
    if (pipe1[57])
      mem[pipe1[52:36]] = merge(mem[pipe1[52:36]], pipe1[35:0], pipe1[56:53]);
    wr_en = pipe1[57];
    wr_word = pipe1[35:0];
    pipe1 = pipe0;
    pipe0 = {bact & bwr, m, ea, w};
    k = !bact ? 2'h0 : (bwr ? 2'h2 : 2'h1);
    nexp = (k == 2'h1) ? mem[ea] : 36'h0;
    advance_or_load_n = ld_n;
    write_strobe_n = we_n;
    {chip_select_a_n, chip_select_b, chip_select_c_n} = sel ? 3'b010 : 3'b101;
    byte_lane_select_n = m;
    address = a;
    @(negedge clk_sys);
    chk_b("bus clash", 1'b0, clash);
    @(posedge clk_sys);
    #1;
    if (kind == 2'h1) begin
      chk_w("read word", rexp, {parity_lines_out, data_out});
      chk_b("drive on read", 1'b1, data_oe);
    end else begin
      chk_b("drive off", 1'b0, data_oe);
    end
    kind = k;
    hexp = rexp;
    rexp = nexp;
  endtask : cyc

  task automatic desel(input int n);
    repeat (n) cyc(1'b0, 1'b1, 1'b0, 4'hf, 17'h0, 36'h0);
  endtask : desel

  task automatic stall();
    clock_qualify_n = 1'b1;
    repeat (3) begin
      @(posedge clk_sys);
      #1;
      chk_w("held word", hexp, {parity_lines_out, data_out});
      chk_b("held drive", 1'b1, data_oe);
    end
    clock_qualify_n = 1'b0;
  endtask : stall

  task automatic oe_gate();
    output_drive_en_n = 1'b1;
    #1;
    chk_b("drive gated", 1'b0, data_oe);
    chk_b("parity gated", 1'b0, parity_lines_oe);
    output_drive_en_n = 1'b0;
    #1;
    chk_b("parity back", 1'b1, parity_lines_oe);
  endtask : oe_gate

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_fill();
    for (int k = 0; k < 4; k++)
      cyc(1'b0, 1'b0, 1'b1, 4'h0, GRP + 17'(k), 36'h912345670 + 36'h111111111 * k);
    desel(2);
  endtask : s_fill

  task automatic s_rd_lin();
    cyc(1'b0, 1'b1, 1'b1, 4'hf, GRP + 17'h1, 36'h0);
    cyc(1'b1, 1'b0, 1'b0, 4'h0, 17'h1ffff, 36'h0);
    oe_gate();
    repeat (3) cyc(1'b1, 1'b0, 1'b0, 4'h0, 17'h1ffff, 36'h0);
    stall();
    cyc(1'b0, 1'b1, 1'b1, 4'hf, GRP + 17'h3, 36'h0);
    cyc(1'b0, 1'b0, 1'b1, 4'h0, GRP, 36'h0a5a5a5a5);
    cyc(1'b0, 1'b1, 1'b1, 4'hf, GRP + 17'h2, 36'h0);
    desel(3);
  endtask : s_rd_lin

  task automatic s_wr_il();
    burst_order_strap = 1'b1;
    desel(3);
    cyc(1'b0, 1'b0, 1'b1, 4'h0, GRP + 17'h2, 36'hf0f0f0f0f);
    cyc(1'b1, 1'b1, 1'b0, 4'ha, 17'h0, 36'h3c3c3c3c3);
    cyc(1'b1, 1'b1, 1'b0, 4'h5, 17'h0, 36'h6e6e6e6e6);
    cyc(1'b1, 1'b1, 1'b0, 4'hf, 17'h0, 36'h0);
    desel(2);
    cyc(1'b0, 1'b1, 1'b1, 4'hf, GRP + 17'h1, 36'h0);
    repeat (3) cyc(1'b1, 1'b1, 1'b1, 4'hf, 17'h0, 36'h0);
    desel(1);
  endtask : s_wr_il

  initial begin
    #20000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    chk_b("drive after reset", 1'b0, data_oe);
    s_fill();
    s_rd_lin();
    s_wr_il();
    print_verdict();
  end
endmodule : tb_bsp_sram_port
